// ---- pkg/misc_ops_map.svh ----
// Constant map for the miscellaneous instruction execution unit
`ifndef MISC_OPS_MAP_SVH
`define MISC_OPS_MAP_SVH

// Condition code bit positions
`define CC_E 7
`define CC_F 6
`define CC_H 5
`define CC_I 4
`define CC_N 3
`define CC_Z 2
`define CC_V 1
`define CC_C 0

// Register select codes
`define R_D 4'h0
`define R_X 4'h1
`define R_Y 4'h2
`define R_U 4'h3
`define R_S 4'h4
`define R_PC 4'h5
`define R_A 4'h8
`define R_B 4'h9
`define R_CC 4'ha
`define R_DP 4'hb
`define R_MEM 4'hf

// Stack sequence lengths and steps
`define WAIT_STEPS 4'hc
`define CALL_STEPS 4'h2
`define PULL_PC_STEP 4'ha
`define PULL_LAST_STEP 4'hb

// Arithmetic constants and reset values
`define BCD_FIX 4'h6
`define BCD_MAX 4'h9
`define BCD_HI_MAX 4'h8
`define DEC_OVF 8'h80
`define INC_OVF 8'h7f
`define REG_RESET 16'h0000
`define CC_RESET 8'h50

`endif

// ---- pkg/misc_ops_pkg.sv ----
// Types of the miscellaneous instruction execution unit
package misc_ops_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_INVERT = 4'b0001,
    OP_WAIT = 4'b0010,
    OP_BCD = 4'b0011,
    OP_DEC = 4'b0100,
    OP_XOR = 4'b0101,
    OP_SWAP = 4'b0110,
    OP_JUMP = 4'b0111,
    OP_CALL = 4'b1000,
    OP_LD8 = 4'b1001,
    OP_LD16 = 4'b1010,
    OP_LEA = 4'b1011,
    OP_RETI = 4'b1100,
    OP_INC = 4'b1101
  } op_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_PUSH = 2'b01,
    PH_WAIT = 2'b10,
    PH_PULL = 2'b11
  } phase_t;

  typedef struct packed {
    op_t op;
    logic [3:0] sel;
    logic [7:0] pbyte;
    logic [15:0] opnd;
    logic [15:0] ea;
    logic self_inc;
  } cmd_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] dp;
    logic [7:0] cc;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] u;
    logic [15:0] s;
    logic [15:0] pc;
  } regs_t;

endpackage

// ---- src/misc_exec_unit.sv ----
// Execution unit for complement, wait, adjust, step, xor, swap, jump, load ops
`timescale 1ns/1ns
`include "misc_ops_map.svh"

// Overview of operation
// - Invert replaces operand with ones complement; N,Z from result, V cleared, C set.
// - Wait ANDs immediate into condition codes, then sets E before stacking.
// - Wait pushes PC, U, Y, X, DP, B, A, CC; predecrement before each byte.
// - After stacking, wait for unmasked interrupt, then vector with no more saving.
// - While waiting, buses stay driven, never released to high impedance.
// - Fast interrupt during wait enters handler with the whole state stacked.
// - Interrupt return tests pulled E and restores the whole state when set.
// - Flag order E F H I N Z V C; immediate clears chosen interrupt masks.
// - Adjust adds 6 to low nibble when C set or low nibble above 9.
// - Adds 6 to high nibble on C, high above 9, or high above 8 with low above 9.
// - Adjust sets N,Z from result; C set on carry or prior C; V undefined.
// - Decrement sets N,Z; V only when operand was 80h; C,H kept.
// - Increment sets N,Z; V only when operand was 7Fh; C,H kept.
// - Xor into A or B; N,Z from result, V cleared, C,H kept.
// - Swap postbyte high and low nibbles select the two registers by code.
// - Only equal widths paired (not checked: any two codes swap); flags unchanged unless condition codes swapped.
// - Jump loads PC with effective address, flags unchanged.
// - Call pushes return PC low then high, predecrementing, then jumps.
// - 8-bit load copies operand into A or B; N,Z set, V cleared.
// - 16-bit load fills D,X,Y,S or U; N,Z from 16 bits, V cleared.
// - Effective address load into X,Y,U,S; only X,Y forms update Z.
// - Post-increment on its own target register leaves that register unchanged.
module misc_exec_unit
  import misc_ops_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire cmd_t cmd_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic irq_n_i,
  input wire logic fast_interrupt_request_n_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic bus_oe_n_o,
  output logic vec_irq_o,
  output logic vec_fast_interrupt_request_o,
  output regs_t regs_o
);

  typedef struct packed {
    phase_t ph;
    regs_t r;
    logic [3:0] step;
    logic [3:0] lim;
    logic rd_pend;
    logic [15:0] tgt;
    logic irq_m;
    logic irq_q;
    logic fast_interrupt_request_m;
    logic fast_interrupt_request_q;
    logic busy;
    logic done;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic bus_oe_n;
    logic vec_irq;
    logic vec_fast_interrupt_request;
  } st_t;

  st_t cur;
  st_t next_st;

  //////////////////////////////////////////////////////////////////////////
  // Register access helpers

  function automatic logic [15:0] rd_reg(input regs_t r, input logic [3:0] c);
    case (c)
      `R_D: rd_reg = {r.a, r.b};
      `R_X: rd_reg = r.x;
      `R_Y: rd_reg = r.y;
      `R_U: rd_reg = r.u;
      `R_S: rd_reg = r.s;
      `R_PC: rd_reg = r.pc;
      `R_A: rd_reg = {8'hff, r.a};
      `R_B: rd_reg = {8'hff, r.b};
      `R_CC: rd_reg = {8'hff, r.cc};
      `R_DP: rd_reg = {8'hff, r.dp};
      default: rd_reg = 16'hffff;
    endcase
  endfunction

  function automatic regs_t wr_reg(input regs_t r, input logic [3:0] c,
                                   input logic [15:0] v);
    regs_t o;
    o = r;
    case (c)
      `R_D: {o.a, o.b} = v;
      `R_X: o.x = v;
      `R_Y: o.y = v;
      `R_U: o.u = v;
      `R_S: o.s = v;
      `R_PC: o.pc = v;
      `R_A: o.a = v[7:0];
      `R_B: o.b = v[7:0];
      `R_CC: o.cc = v[7:0];
      `R_DP: o.dp = v[7:0];
      default: o = r;
    endcase
    return o;
  endfunction

  function automatic logic [7:0] nz(input logic [7:0] cc, input logic [15:0] v,
                                    input logic wide);
    logic [7:0] o;
    o = cc;
    o[`CC_N] = wide ? v[15] : v[7];
    o[`CC_Z] = wide ? (v == 16'h0000) : (v[7:0] == 8'h00);
    return o;
  endfunction

  // Byte sent at each push step, return address first
  function automatic logic [7:0] push_byte(input regs_t r, input logic [3:0] k);
    case (k)
      4'h0: push_byte = r.pc[7:0];
      4'h1: push_byte = r.pc[15:8];
      4'h2: push_byte = r.u[7:0];
      4'h3: push_byte = r.u[15:8];
      4'h4: push_byte = r.y[7:0];
      4'h5: push_byte = r.y[15:8];
      4'h6: push_byte = r.x[7:0];
      4'h7: push_byte = r.x[15:8];
      4'h8: push_byte = r.dp;
      4'h9: push_byte = r.b;
      4'ha: push_byte = r.a;
      default: push_byte = r.cc;
    endcase
  endfunction

  // Register filled at each pull step, mirror of the push order
  function automatic regs_t pull_put(input regs_t r, input logic [3:0] k,
                                     input logic [7:0] d);
    regs_t o;
    o = r;
    case (k)
      4'h0: o.cc = d;
      4'h1: o.a = d;
      4'h2: o.b = d;
      4'h3: o.dp = d;
      4'h4: o.x[15:8] = d;
      4'h5: o.x[7:0] = d;
      4'h6: o.y[15:8] = d;
      4'h7: o.y[7:0] = d;
      4'h8: o.u[15:8] = d;
      4'h9: o.u[7:0] = d;
      4'ha: o.pc[15:8] = d;
      default: o.pc[7:0] = d;
    endcase
    return o;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] src;
    logic [7:0] res;
    logic [15:0] v1;
    logic [15:0] v2;
    logic [3:0] lo;
    logic [3:0] hi;
    logic [3:0] fl;
    logic [3:0] fh;
    logic [8:0] sum;
    logic mem_tgt;
    next_st = cur;
    src = 8'h00;
    res = 8'h00;
    v1 = 16'h0000;
    v2 = rd_reg(cur.r, cmd_i.sel);
    lo = cur.r.a[3:0];
    hi = cur.r.a[7:4];
    fl = 4'h0;
    fh = 4'h0;
    sum = 9'h000;
    mem_tgt = (cmd_i.sel == `R_MEM);
    next_st.irq_m = irq_n_i;
    next_st.irq_q = cur.irq_m;
    next_st.fast_interrupt_request_m = fast_interrupt_request_n_i;
    next_st.fast_interrupt_request_q = cur.fast_interrupt_request_m;
    next_st.done = 1'b0;
    next_st.mem_we = 1'b0;
    next_st.mem_re = 1'b0;
    next_st.vec_irq = 1'b0;
    next_st.vec_fast_interrupt_request = 1'b0;
    next_st.bus_oe_n = 1'b0;
    case (cur.ph)
      PH_IDLE: begin
        if (cmd_valid_i) begin
          src = mem_tgt ? cmd_i.opnd[7:0] : v2[7:0];
          next_st.done = 1'b1;
          case (cmd_i.op)
            OP_INVERT, OP_DEC, OP_INC: begin
              if (cmd_i.op == OP_INVERT) begin
                res = ~src;
                next_st.r.cc[`CC_V] = 1'b0;
                next_st.r.cc[`CC_C] = 1'b1;
              end else if (cmd_i.op == OP_DEC) begin
                res = src - 8'h01;
                next_st.r.cc[`CC_V] = (src == `DEC_OVF);
              end else begin
                res = src + 8'h01;
                next_st.r.cc[`CC_V] = (src == `INC_OVF);
              end
              next_st.r.cc = nz(next_st.r.cc, {8'h00, res}, 1'b0);
              if (mem_tgt) begin
                next_st.mem_we = 1'b1;
                next_st.mem_addr = cmd_i.ea;
                next_st.mem_wdata = res;
              end else begin
                next_st.r = wr_reg(next_st.r, cmd_i.sel, {8'h00, res});
              end
            end
            OP_XOR, OP_LD8: begin
              res = (cmd_i.op == OP_XOR) ? (src ^ cmd_i.opnd[7:0])
                                         : cmd_i.opnd[7:0];
              next_st.r = wr_reg(cur.r, cmd_i.sel, {8'h00, res});
              next_st.r.cc = nz(cur.r.cc, {8'h00, res}, 1'b0);
              next_st.r.cc[`CC_V] = 1'b0;
            end
            OP_LD16: begin
              next_st.r = wr_reg(cur.r, cmd_i.sel, cmd_i.opnd);
              next_st.r.cc = nz(cur.r.cc, cmd_i.opnd, 1'b1);
              next_st.r.cc[`CC_V] = 1'b0;
            end
            OP_BCD: begin
              if (cur.r.cc[`CC_C] || lo > `BCD_MAX) begin
                fl = `BCD_FIX;
              end
              if (cur.r.cc[`CC_C] || hi > `BCD_MAX ||
                  (hi > `BCD_HI_MAX && lo > `BCD_MAX)) begin
                fh = `BCD_FIX;
              end
              sum = {1'b0, cur.r.a} + {1'b0, fh, fl};
              next_st.r.a = sum[7:0];
              next_st.r.cc = nz(cur.r.cc, {8'h00, sum[7:0]}, 1'b0);
              next_st.r.cc[`CC_C] = sum[8] | cur.r.cc[`CC_C];
            end
            OP_SWAP: begin
              v1 = rd_reg(cur.r, cmd_i.pbyte[7:4]);
              v2 = rd_reg(cur.r, cmd_i.pbyte[3:0]);
              next_st.r = wr_reg(wr_reg(cur.r, cmd_i.pbyte[7:4], v2),
                                 cmd_i.pbyte[3:0], v1);
            end
            OP_JUMP: begin
              next_st.r.pc = cmd_i.ea;
            end
            OP_LEA: begin
              v1 = cmd_i.self_inc ? rd_reg(cur.r, cmd_i.sel) : cmd_i.ea;
              next_st.r = wr_reg(cur.r, cmd_i.sel, v1);
              if (cmd_i.sel == `R_X || cmd_i.sel == `R_Y) begin
                next_st.r.cc[`CC_Z] = (v1 == 16'h0000);
              end
            end
            OP_CALL: begin
              next_st.done = 1'b0;
              next_st.tgt = cmd_i.ea;
              next_st.step = 4'h0;
              next_st.lim = `CALL_STEPS;
              next_st.ph = PH_PUSH;
            end
            OP_WAIT: begin
              next_st.done = 1'b0;
              next_st.r.cc = cur.r.cc & cmd_i.pbyte;
              next_st.r.cc[`CC_E] = 1'b1;
              next_st.step = 4'h0;
              next_st.lim = `WAIT_STEPS;
              next_st.ph = PH_PUSH;
            end
            OP_RETI: begin
              next_st.done = 1'b0;
              next_st.step = 4'h0;
              next_st.rd_pend = 1'b0;
              next_st.ph = PH_PULL;
            end
            default: begin
              next_st.done = 1'b0;
            end
          endcase
        end
      end
      PH_PUSH: begin
        next_st.r.s = cur.r.s - 16'h0001;
        next_st.mem_addr = cur.r.s - 16'h0001;
        next_st.mem_wdata = push_byte(cur.r, cur.step);
        next_st.mem_we = 1'b1;
        next_st.step = cur.step + 4'h1;
        if (cur.step == cur.lim - 4'h1) begin
          if (cur.lim == `CALL_STEPS) begin
            next_st.r.pc = cur.tgt;
            next_st.done = 1'b1;
            next_st.ph = PH_IDLE;
          end else begin
            next_st.ph = PH_WAIT;
          end
        end
      end
      PH_WAIT: begin
        if (!cur.fast_interrupt_request_q && !cur.r.cc[`CC_F]) begin
          next_st.vec_fast_interrupt_request = 1'b1;
          next_st.r.cc[`CC_F] = 1'b1;
          next_st.r.cc[`CC_I] = 1'b1;
          next_st.done = 1'b1;
          next_st.ph = PH_IDLE;
        end else if (!cur.irq_q && !cur.r.cc[`CC_I]) begin
          next_st.vec_irq = 1'b1;
          next_st.r.cc[`CC_I] = 1'b1;
          next_st.done = 1'b1;
          next_st.ph = PH_IDLE;
        end
      end
      PH_PULL: begin
        if (!cur.rd_pend) begin
          next_st.mem_re = 1'b1;
          next_st.mem_addr = cur.r.s;
          next_st.r.s = cur.r.s + 16'h0001;
          next_st.rd_pend = 1'b1;
        end else begin
          next_st.rd_pend = 1'b0;
          next_st.r = pull_put(cur.r, cur.step, mem_rdata_i);
          if (cur.step == 4'h0 && !mem_rdata_i[`CC_E]) begin
            next_st.step = `PULL_PC_STEP;
          end else begin
            next_st.step = cur.step + 4'h1;
          end
          if (cur.step == `PULL_LAST_STEP) begin
            next_st.done = 1'b1;
            next_st.ph = PH_IDLE;
          end
        end
      end
      default: begin
        next_st.ph = PH_IDLE;
      end
    endcase
    next_st.busy = (next_st.ph != PH_IDLE);
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur <= '0;
      cur.r.cc <= `CC_RESET;
      cur.r.s <= `REG_RESET;
      cur.irq_m <= 1'b1;
      cur.irq_q <= 1'b1;
      cur.fast_interrupt_request_m <= 1'b1;
      cur.fast_interrupt_request_q <= 1'b1;
    end else begin
      cur <= next_st;
    end
  end

  assign busy_o = cur.busy;
  assign done_o = cur.done;
  assign mem_addr_o = cur.mem_addr;
  assign mem_wdata_o = cur.mem_wdata;
  assign mem_we_o = cur.mem_we;
  assign mem_re_o = cur.mem_re;
  assign bus_oe_n_o = cur.bus_oe_n;
  assign vec_irq_o = cur.vec_irq;
  assign vec_fast_interrupt_request_o = cur.vec_fast_interrupt_request;
  assign regs_o = cur.r;

endmodule

// ---- verification/misc_exec_unit_properties.sv ----
// Port-level checker for the miscellaneous execution unit
`timescale 1ns/1ns
`include "misc_ops_map.svh"
module misc_exec_checker
  import misc_ops_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire cmd_t cmd_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic irq_n_i,
  input wire logic fast_interrupt_request_n_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_we_o,
  input wire logic mem_re_o,
  input wire logic bus_oe_n_o,
  input wire logic vec_irq_o,
  input wire logic vec_fast_interrupt_request_o,
  input wire regs_t regs_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic take;
  assign take = cmd_valid_i && !busy_o;
  ////////////////////////////////////////////////////////////////////////////////
  property p_bus_driven;
    !bus_oe_n_o;
  endproperty
  a_bus_driven: assert property (p_bus_driven) else $error("bus released");
  property p_stack_predec;
    $past(busy_o) && mem_we_o && $past(mem_we_o) |-> mem_addr_o == $past(mem_addr_o) - 16'h1;
  endproperty
  a_stack_predec: assert property (p_stack_predec) else $error("push address");
  property p_call_push;
    take && cmd_i.op == OP_CALL |=> busy_o ##1 (mem_we_o && mem_addr_o == $past(regs_o.s, 2)
      - 16'h1 && mem_wdata_o == $past(regs_o.pc[7:0], 2)) ##1 (mem_we_o && done_o
      && mem_wdata_o == $past(regs_o.pc[15:8], 3) && regs_o.pc == $past(cmd_i.ea, 3));
  endproperty
  a_call_push: assert property (p_call_push) else $error("call sequence");
  property p_invert_mem;
    take && cmd_i.op == OP_INVERT && cmd_i.sel == `R_MEM |=> mem_we_o && done_o
      && mem_addr_o == $past(cmd_i.ea) && mem_wdata_o == ~$past(cmd_i.opnd[7:0])
      && regs_o.cc[`CC_C] && !regs_o.cc[`CC_V] && regs_o.cc[`CC_N] == mem_wdata_o[7];
  endproperty
  a_invert_mem: assert property (p_invert_mem) else $error("invert result");
  property p_inc_mem;
    take && cmd_i.op == OP_INC && cmd_i.sel == `R_MEM |=> mem_we_o
      && mem_wdata_o == $past(cmd_i.opnd[7:0]) + 8'h01 && regs_o.cc[`CC_C] == $past(regs_o.cc[0])
      && regs_o.cc[`CC_V] == ($past(cmd_i.opnd[7:0]) == 8'h7f);
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment result");
  property p_dec_mem;
    take && cmd_i.op == OP_DEC && cmd_i.sel == `R_MEM |=> mem_we_o
      && mem_wdata_o == $past(cmd_i.opnd[7:0]) - 8'h01 && regs_o.cc[`CC_H] == $past(regs_o.cc[5])
      && regs_o.cc[`CC_V] == ($past(cmd_i.opnd[7:0]) == 8'h80);
  endproperty
  a_dec_mem: assert property (p_dec_mem) else $error("decrement result");
  property p_xor_acc;
    take && cmd_i.op == OP_XOR && cmd_i.sel == `R_A |=> done_o && !regs_o.cc[`CC_V]
      && regs_o.a == ($past(regs_o.a) ^ $past(cmd_i.opnd[7:0]))
      && regs_o.cc[`CC_C] == $past(regs_o.cc[0]);
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor result");
  property p_ld16;
    take && cmd_i.op == OP_LD16 && cmd_i.sel == `R_X |=> regs_o.x == $past(cmd_i.opnd)
      && regs_o.cc[`CC_N] == regs_o.x[15] && !regs_o.cc[`CC_V];
  endproperty
  a_ld16: assert property (p_ld16) else $error("wide load");
  property p_wait_cc;
    take && cmd_i.op == OP_WAIT |=> busy_o
      && regs_o.cc == (($past(regs_o.cc) & $past(cmd_i.pbyte)) | 8'h80);
  endproperty
  a_wait_cc: assert property (p_wait_cc) else $error("wait flags");
  property p_fast_interrupt_request_unmasked;
    vec_fast_interrupt_request_o |-> done_o && !$past(regs_o.cc[`CC_F]);
  endproperty
  a_fast_interrupt_request_unmasked: assert property (p_fast_interrupt_request_unmasked) else $error("fast vector");
  property p_irq_unmasked;
    vec_irq_o |-> done_o && !$past(regs_o.cc[`CC_I]) && !vec_fast_interrupt_request_o;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked) else $error("normal vector");
  property p_jump;
    take && cmd_i.op == OP_JUMP |=> done_o && regs_o.pc == $past(cmd_i.ea)
      && regs_o.cc == $past(regs_o.cc);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target");
endmodule
bind misc_exec_unit misc_exec_checker misc_exec_checker_inst (.clk_sys_i, .nrst_i,
  .cmd_valid_i, .cmd_i, .mem_rdata_i, .irq_n_i, .fast_interrupt_request_n_i, .busy_o, .done_o, .mem_addr_o,
  .mem_wdata_o, .mem_we_o, .mem_re_o, .bus_oe_n_o, .vec_irq_o, .vec_fast_interrupt_request_o, .regs_o);

// ---- verification/bus_memory_model.sv ----
// Byte memory standing on the processor bus
`timescale 1ns/1ns
module bus_memory_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  // Read data stands only while the read strobe is high, scrambled otherwise
  always @(posedge clk_sys_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
  end
  assign rdata_o = re_i ? mem[addr_i] : ~mem[addr_i];
endmodule

// ---- verification/misc_exec_unit_tb.sv ----
// Self-checking bench for the miscellaneous execution unit
`timescale 1ns/1ns
`include "misc_ops_map.svh"
module misc_exec_unit_tb
  import misc_ops_pkg::*;
;
  logic clk_sys_i, nrst_i, cmd_valid_i, irq_n_i, fast_interrupt_request_n_i;
  cmd_t cmd_i;
  logic [7:0] mem_rdata_i, mem_wdata_o;
  logic [15:0] mem_addr_o;
  logic busy_o, done_o, mem_we_o, mem_re_o, bus_oe_n_o, vec_irq_o, vec_fast_interrupt_request_o;
  regs_t regs_o;
  int fail_count = 0;
  int tests_run = 0;
  misc_exec_unit misc_exec_unit_inst (.clk_sys_i, .nrst_i, .cmd_valid_i, .cmd_i, .mem_rdata_i,
    .irq_n_i, .fast_interrupt_request_n_i, .busy_o, .done_o, .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o,
    .bus_oe_n_o, .vec_irq_o, .vec_fast_interrupt_request_o, .regs_o);
  bus_memory_model bus_memory_model_inst (.clk_sys_i, .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .we_i(mem_we_o), .re_i(mem_re_o), .rdata_o(mem_rdata_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] m(input logic [15:0] a);
    return {8'h00, bus_memory_model_inst.mem[a]};
  endfunction
  function automatic logic [8:0] daa_exp(input logic [7:0] a, input logic c);
    logic [3:0] lo, hi;
    logic [8:0] s;
    lo = (c || a[3:0] > 4'h9) ? 4'h6 : 4'h0;
    hi = (c || a[7:4] > 4'h9 || (a[7:4] > 4'h8 && a[3:0] > 4'h9)) ? 4'h6 : 4'h0;
    s = {1'b0, a} + {1'b0, hi, lo};
    return {s[8] | c, s[7:0]};
  endfunction
  task automatic wait_done();
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_sys_i);
      if (done_o === 1'b1) break;
    end
    chk({15'h0, done_o}, 16'h1);
  endtask
  task automatic issue(input op_t op, input logic [3:0] sel, input logic [15:0] opnd,
    input logic [15:0] ea = 16'h0, input logic [7:0] pb = 8'h0, input logic si = 1'b0,
    input logic wt = 1'b1);
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op, sel, pb, opnd, ea, si};
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    if (wt) begin
      wait_done();
      // Let a memory write launched with done land before it is read back
      @(negedge clk_sys_i);
    end
  endtask
  task automatic give_verdict();
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] r, q, cv;
    logic [8:0] e;
    logic [15:0] w;
    logic [7:0] frame [12];
    nrst_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    irq_n_i = 1'b1;
    fast_interrupt_request_n_i = 1'b1;
    frame = '{8'h00, 8'h40, 8'h34, 8'h12, 8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h5a, 8'hb9};
    void'($urandom(32'h6941));
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    chk({8'h0, regs_o.cc}, 16'h0050);
    chk({15'h0, bus_oe_n_o}, 16'h0);
    for (int k = 0; k < 12; k++) begin
      r = (k == 0) ? 8'h9a : (k == 1) ? 8'h99 : 8'($urandom);
      q = 8'($urandom);
      q[0] = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : q[0];
      cv = 8'h50 | {7'h0, q[0]};
      issue(OP_LD8, `R_A, {8'h0, cv});
      issue(OP_SWAP, `R_A, 16'h0, 16'h0, 8'h8a);
      issue(OP_LD8, `R_A, {8'h0, r});
      chk({8'h0, regs_o.a}, {8'h0, r});
      e = daa_exp(r, q[0]);
      issue(OP_BCD, `R_A, 16'h0);
      chk({8'h0, regs_o.a}, {8'h0, e[7:0]});
      chk({13'h0, regs_o.cc[3:2], regs_o.cc[0]}, {13'h0, e[7], e[7:0] == 8'h0, e[8]});
      issue(OP_XOR, `R_A, {8'h0, q});
      chk({8'h0, regs_o.a}, {8'h0, e[7:0] ^ q});
      issue(OP_INC, `R_MEM, {8'h0, k == 0 ? 8'h7f : r}, 16'h0200);
      chk(m(16'h0200), {8'h0, (k == 0 ? 8'h7f : r) + 8'h01});
      issue(OP_DEC, `R_MEM, {8'h0, k == 0 ? 8'h80 : q}, 16'h0201);
      chk(m(16'h0201), {8'h0, (k == 0 ? 8'h80 : q) - 8'h01});
      issue(OP_INVERT, `R_MEM, {8'h0, r}, 16'h0202);
      chk(m(16'h0202), {8'h0, ~r});
    end
    w = 16'($urandom);
    issue(OP_LD16, `R_S, 16'h0400);
    issue(OP_LD16, `R_X, 16'h8001);
    chk({15'h0, regs_o.cc[3]}, 16'h1);
    issue(OP_LD16, `R_Y, w);
    issue(OP_SWAP, `R_X, 16'h0, 16'h0, 8'h12);
    chk(regs_o.x, w);
    chk(regs_o.y, 16'h8001);
    issue(OP_LD16, `R_U, 16'h1234);
    issue(OP_LEA, `R_X, 16'h0, 16'h5555, 8'h0, 1'b1);
    chk(regs_o.x, w);
    issue(OP_LEA, `R_X, 16'h0, 16'h0000);
    chk({regs_o.x[14:0], regs_o.cc[2]}, 16'h0001);
    issue(OP_JUMP, `R_A, 16'h0, 16'h3000);
    issue(OP_CALL, `R_A, 16'h0, 16'h4000);
    chk((m(16'h03ff) << 8) | m(16'h03fe), 16'h0030);
    chk(regs_o.s, 16'h03fe);
    issue(OP_LD8, `R_A, 16'h00ff);
    issue(OP_SWAP, `R_A, 16'h0, 16'h0, 8'h8a);
    issue(OP_LD8, `R_A, 16'h005a);
    issue(OP_LD8, `R_B, 16'h00a5);
    issue(OP_WAIT, `R_A, 16'h0, 16'h0, 8'hbf, 1'b0, 1'b0);
    @(negedge clk_sys_i);
    chk({8'h0, regs_o.cc}, 16'h00b9);
    repeat (30) @(posedge clk_sys_i);
    irq_n_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk({15'h0, busy_o}, 16'h1);
    fast_interrupt_request_n_i <= 1'b0;
    wait_done();
    chk({15'h0, vec_fast_interrupt_request_o}, 16'h1);
    for (int i = 0; i < 12; i++) begin
      chk(m(16'h03fd - 16'(i)), {8'h0, frame[i]});
    end
    @(posedge clk_sys_i);
    irq_n_i <= 1'b1;
    fast_interrupt_request_n_i <= 1'b1;
    issue(OP_LD8, `R_A, 16'h0000);
    issue(OP_LD16, `R_X, 16'hffff);
    issue(OP_RETI, `R_A, 16'h0);
    chk({regs_o.a, regs_o.cc}, 16'h5ab9);
    chk(regs_o.x ^ regs_o.pc ^ regs_o.s, 16'h43fe);
    // Wait with both interrupts unmasked, only the normal one requested
    issue(OP_WAIT, `R_A, 16'h0, 16'h0, 8'hef, 1'b0, 1'b0);
    irq_n_i <= 1'b0;
    wait_done();
    chk({15'h0, vec_irq_o}, 16'h1);
    chk({8'h0, regs_o.cc}, 16'h00b9);
    chk(regs_o.s, 16'h03f2);
    @(posedge clk_sys_i);
    irq_n_i <= 1'b1;
    give_verdict();
  end
endmodule
